// [dv/mbrw_store_model.sv]
// register store model on the far side of the handler's store ports
// assumes one write strobe per word and one read pulse per word
`timescale 1ns/10ps
`default_nettype none
module mbrw_store_model (
  input  wire logic               sys_clk,
  input  wire mbrw_pkg::mbrw_wr_t wr,
  input  wire logic               rd_en,
  input  wire logic [15:0]        rd_addr,
  output var  logic [15:0]        rd_data
);
  import mbrw_pkg::*;
  logic [15:0] mem [int];
  initial rd_data = 16'h0000;
  // ==========================================================
  // storage
  // writes land first, so a read in the same cycle sees them
  always @(posedge sys_clk) begin
    if (wr.en === 1'b1) mem[wr.addr] = wr.data;
    if (rd_en === 1'b1) rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : rd_addr ^ 16'h5a5a;
    else rd_data <= ~rd_data; // read data held one cycle only
  end
endmodule : mbrw_store_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the write-multiple and read/write handler
// assumes the store model answers reads one cycle after rd_en
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mbrw_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        is_tcp = 1'b1;
  logic        tx_ready = 1'b1;
  logic        rx_ready, rd_en;
  logic [15:0] rd_addr, rd_data;
  mbrw_rx_t    rx = '0;
  mbrw_tx_t    tx;
  mbrw_wr_t    wr;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [7:0]  exp_tx[$];
  logic [31:0] exp_wr[$];
  logic [7:0]  req[$];
  logic [15:0] shadow[int];
  mbrw_handler u_mbrw_handler (.sys_clk(sys_clk), .rst(rst), .rx(rx), .is_tcp(is_tcp), .rx_ready(rx_ready),
    .tx(tx), .tx_ready(tx_ready), .wr(wr), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  mbrw_store_model u_mbrw_store_model (.sys_clk(sys_clk), .wr(wr), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data));
  initial forever #5 sys_clk = ~sys_clk;
  // ==========================================================
  // reporting
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  // ==========================================================
  // monitors: answer bytes and store writes against the model
  always @(posedge sys_clk) begin
    if (!rst && tx.valid === 1'b1 && tx_ready) begin
      check(exp_tx.size() > 0 && tx.data === exp_tx[0] && tx.last === (exp_tx.size() == 1), "answer");
      if (exp_tx.size() > 0) void'(exp_tx.pop_front());
    end
    if (!rst && wr.en === 1'b1) begin
      check(exp_wr.size() > 0 && {wr.addr, wr.data} === exp_wr[0], "store write");
      if (exp_wr.size() > 0) void'(exp_wr.pop_front());
    end
  end
  // downstream stalls at random
  always @(negedge sys_clk) tx_ready = $urandom_range(3) != 0;
  // ==========================================================
  // request driving
  function automatic void push16(input logic [15:0] v);
    req.push_back(v[15:8]);
    req.push_back(v[7:0]);
  endfunction : push16
  task automatic send(input logic tcp);
    int n;
    for (int i = 0; i < req.size(); i++) begin
      n = 0;
      @(negedge sys_clk);
      while (rx_ready !== 1'b1 && n < 2000) begin
        @(negedge sys_clk);
        n++;
      end
      if (n == 2000) check(1'b0, "request stalled");
      if (n == 2000) tally_and_finish();
      is_tcp = tcp;
      rx = '{valid: 1'b1, first: i == 0, last: i == req.size() - 1, data: req[i]};
    end
    @(negedge sys_clk);
    rx = '{valid: 1'b0, first: 1'b0, last: 1'b0, data: 8'($urandom)};
    n = 0;
    while ((exp_tx.size() != 0 || rx_ready !== 1'b1) && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 3000) check(1'b0, "answer incomplete");
    if (n == 3000) tally_and_finish();
    check(exp_wr.size() == 0, "writes missing");
  endtask : send
  task automatic do_fc16(input logic tcp, input logic [15:0] a, input logic [15:0] q, input logic [7:0] bc);
    logic [15:0] w, ad;
    logic good;
    good = q >= 1 && q <= 123 && bc == 2 * q;
    req = {8'h10};
    push16(a);
    push16(q);
    req.push_back(bc);
    for (int i = 0; i < q; i++) begin
      w = 16'($urandom);
      ad = a + 16'(i);
      push16(w);
      if (good) exp_wr.push_back({ad, w});
      if (good) shadow[ad] = w;
    end
    if (good) exp_tx = {8'h10, a[15:8], a[7:0], q[15:8], q[7:0]};
    else exp_tx = {8'h90, 8'h03};
    send(tcp);
  endtask : do_fc16
  task automatic do_fc23(input logic tcp, input logic [15:0] ra, rq, wa, wq);
    logic [15:0] w, ad;
    logic good;
    good = tcp && rq >= 1 && rq <= 125 && wq >= 1 && wq <= 121;
    req = {8'h17};
    push16(ra);
    push16(rq);
    push16(wa);
    push16(wq);
    req.push_back(8'(2 * wq));
    for (int i = 0; i < wq; i++) begin
      w = 16'($urandom);
      ad = wa + 16'(i);
      push16(w);
      if (good) exp_wr.push_back({ad, w});
      if (good) shadow[ad] = w;
    end
    if (tcp) exp_tx = {8'h97, 8'h03};
    else exp_tx = {8'h97, 8'h01};
    if (good) exp_tx = {8'h17, 8'(2 * rq)};
    for (int i = 0; good && i < rq; i++) begin
      ad = ra + 16'(i);
      w = shadow.exists(ad) ? shadow[ad] : ad ^ 16'h5a5a;
      exp_tx.push_back(w[15:8]);
      exp_tx.push_back(w[7:0]);
    end
    send(tcp);
  endtask : do_fc23
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h2a9e2f84));
    repeat (10) @(posedge sys_clk);
    check(rx_ready === 1'b1 && tx === '0 && wr === '0 && rd_en === 1'b0, "reset state");
    @(negedge sys_clk);
    rst = 1'b0;
    do_fc16(1'b1, 16'h002f, 16'h0002, 8'h04);
    do_fc16(1'b0, 16'h002f, 16'h0002, 8'h04);
    do_fc16(1'b1, 16'h0100, 16'd123, 8'd246);
    do_fc16(1'b1, 16'h002f, 16'h0002, 8'h03);
    do_fc16(1'b0, 16'h0040, 16'h0000, 8'h00);
    do_fc23(1'b1, 16'h0030, 16'h0003, 16'h002f, 16'h0002);
    do_fc23(1'b1, 16'h0000, 16'd125, 16'h0000, 16'd121);
    do_fc23(1'b0, 16'h0030, 16'h0001, 16'h0030, 16'h0001);
    do_fc23(1'b1, 16'h0030, 16'd126, 16'h0030, 16'h0001);
    do_fc23(1'b1, 16'h0030, 16'h0001, 16'h0030, 16'd122);
    // frame cut after one of two words: that word stays written, answer is an error
    req = {8'h10, 8'h00, 8'h50, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34};
    exp_wr.push_back({16'h0050, 16'h1234});
    shadow[16'h0050] = 16'h1234;
    exp_tx = {8'h90, 8'h03};
    send(1'b1);
    req = {8'h03, 8'h00, 8'h2f, 8'h00, 8'h01};
    exp_tx = {8'h83, 8'h01};
    send(1'b1);
    repeat (4) do_fc23(1'b1, 16'($urandom_range(63)), 16'($urandom_range(1, 8)), 16'($urandom_range(63)),
      16'($urandom_range(1, 8)));
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// [rtl/mbrw_handler.sv]
// command handler for write-multiple and read/write-multiple requests
// assumes a checked data unit stream and a store with one-cycle read latency
`include "mbrw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module mbrw_handler (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire mbrw_pkg::mbrw_rx_t rx,
  input  wire logic              is_tcp,
  output var  logic              rx_ready,
  output var  mbrw_pkg::mbrw_tx_t tx,
  input  wire logic              tx_ready,
  output var  mbrw_pkg::mbrw_wr_t wr,
  output var  logic              rd_en,
  output var  logic [15:0]       rd_addr,
  input  wire logic [15:0]       rd_data
);
  import mbrw_pkg::*;

  // ==========================================================
  // request capture
  // ==========================================================
  logic [7:0]  h [`MBRW_HDR_SLOTS];
  logic [8:0]  idx;
  logic [7:0]  exc;
  logic [7:0]  next_exc;
  logic        tcp_q;
  logic        err;
  logic        f23;
  logic [8:0]  hl;
  logic [8:0]  p;
  logic [8:0]  dn;
  logic [8:0]  exp_last;
  logic [15:0] a_wr;
  logic [15:0] q_wr;
  logic [15:0] a_rd;
  logic [15:0] q_rd;
  logic        rx_fire;
  logic        bc_ok;
  mbrw_state_t st;
  logic [3:0]  hc;
  logic [6:0]  k;
  logic [7:0]  rlo;
  logic        free;

  function automatic logic qty_ok(input logic [15:0] q, input logic [15:0] max);
    qty_ok = (q != 16'h0000) && (q <= max);
  endfunction : qty_ok

  // field layout differs by function code
  assign rx_fire  = rx.valid && rx_ready;
  assign p        = rx.first ? 9'h000 : idx;
  assign f23      = (h[0] == `MBRW_FC_RW_MULTI);
  assign hl       = f23 ? `MBRW_HDR23_LEN : `MBRW_HDR16_LEN;
  assign a_rd     = {h[1], h[2]};
  assign q_rd     = {h[3], h[4]};
  assign a_wr     = f23 ? {h[5], h[6]} : {h[1], h[2]};
  assign q_wr     = f23 ? {h[7], h[8]} : {h[3], h[4]};
  assign dn       = p - hl;
  assign exp_last = 9'(hl + {q_wr[7:0], 1'b0} - 9'h001);
  assign err      = (exc != `MBRW_EXC_NONE);
  assign free     = !tx.valid;

  // byte count and quantity checks at the byte count slot
  assign bc_ok = (rx.data == {q_wr[6:0], 1'b0})
              && qty_ok(q_wr, f23 ? `MBRW_Q23_WR_MAX : `MBRW_Q16_MAX)
              && (!f23 || qty_ok(q_rd, `MBRW_Q23_RD_MAX));

  // exception code for the frame in flight
  always_comb begin
    next_exc = exc;
    if (p == 9'h000) begin
      if (rx.data == `MBRW_FC_WR_MULTI)
        next_exc = `MBRW_EXC_NONE;
      else if (rx.data == `MBRW_FC_RW_MULTI && is_tcp)
        next_exc = `MBRW_EXC_NONE;
      else
        next_exc = `MBRW_EXC_ILL_FUNC;
    end else if (p == hl - 9'h001 && exc == `MBRW_EXC_NONE && !bc_ok) begin
      next_exc = `MBRW_EXC_ILL_VALUE;
    end
    if (rx.last && next_exc == `MBRW_EXC_NONE && (p < hl || p != exp_last))
      next_exc = `MBRW_EXC_ILL_VALUE;
  end

  // header bytes, position and error state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MBRW_HDR_SLOTS; i++) h[i] <= 8'h00;
      idx   <= 9'h000;
      exc   <= `MBRW_EXC_NONE;
      tcp_q <= 1'b0;
    end else if (rx_fire) begin
      if (p < 9'(`MBRW_HDR_SLOTS))
        h[p[3:0]] <= rx.data;
      if (p == 9'h000)
        tcp_q <= is_tcp;
      idx <= (p == 9'h1ff) ? p : p + 9'h001;
      exc <= next_exc;
    end
  end

  // ==========================================================
  // register writes, streamed as words complete
  // ==========================================================
  logic [7:0] whi;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr  <= '0;
      whi <= 8'h00;
    end else begin
      wr.en <= 1'b0;
      if (rx_fire && !err && p >= hl && dn[8:1] < q_wr[8:0]) begin
        if (!dn[0]) begin
          whi <= rx.data;
        end else begin
          wr.en   <= 1'b1;
          wr.addr <= a_wr + 16'(dn[8:1]);
          wr.data <= {whi, rx.data};
        end
      end
    end
  end

  // ==========================================================
  // answer sequencing and reads
  // ==========================================================
  function automatic logic [7:0] rsp_byte(input logic [3:0] n);
    rsp_byte = h[0];
    if (err)
      rsp_byte = (n == 4'h0) ? (h[0] | `MBRW_EXC_FLAG) : exc;
    else if (f23)
      rsp_byte = (n == 4'h0) ? h[0] : {q_rd[6:0], 1'b0};
    else
      case (n)
        4'h1:    rsp_byte = a_wr[15:8];
        4'h2:    rsp_byte = a_wr[7:0];
        4'h3:    rsp_byte = q_wr[15:8];
        4'h4:    rsp_byte = q_wr[7:0];
        default: rsp_byte = h[0];
      endcase
  endfunction : rsp_byte

  logic [3:0] hdr_n;
  assign hdr_n = (err || f23) ? `MBRW_RSP_SHORT : `MBRW_RSP16_LEN;

  // main state machine, owns the answer stream
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st       <= S_RX;
      rx_ready <= 1'b1;
      tx       <= '0;
      hc       <= 4'h0;
      k        <= 7'h00;
      rlo      <= 8'h00;
      rd_en    <= 1'b0;
      rd_addr  <= 16'h0000;
    end else begin
      if (tx.valid && tx_ready)
        tx.valid <= 1'b0;
      case (st)
        S_RX: begin
          if (rx_fire && rx.last) begin
            rx_ready <= 1'b0;
            hc       <= 4'h0;
            st       <= S_HDR;
          end
        end
        S_HDR: begin
          if (free) begin
            tx.valid <= 1'b1;
            tx.data  <= rsp_byte(hc);
            tx.last  <= (hc == hdr_n - 4'h1) && (err || !f23);
            hc       <= hc + 4'h1;
            k        <= 7'h00;
            if (hc == hdr_n - 4'h1)
              st <= (err || !f23) ? S_END : S_RDREQ;
          end
        end
        S_RDREQ: begin
          if (free) begin
            rd_en   <= 1'b1;
            rd_addr <= a_rd + 16'(k);
            st      <= S_RDCAP;
          end
        end
        S_RDCAP: begin
          rd_en <= 1'b0;
          st    <= S_DHI;
        end
        S_DHI: begin
          tx.valid <= 1'b1;
          tx.data  <= rd_data[15:8];
          tx.last  <= 1'b0;
          rlo      <= rd_data[7:0];
          st       <= S_DLO;
        end
        S_DLO: begin
          if (free) begin
            tx.valid <= 1'b1;
            tx.data  <= rlo;
            tx.last  <= (16'(k) == q_rd - 16'h0001);
            k        <= k + 7'h01;
            st       <= (16'(k) == q_rd - 16'h0001) ? S_END : S_RDREQ;
          end
        end
        S_END: begin
          if (free) begin
            rx_ready <= 1'b1;
            st       <= S_RX;
          end
        end
        default: st <= S_RX;
      endcase
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  chk_fc16_echo_code: assert property (@(posedge sys_clk) disable iff (rst)
    (st == S_HDR && free && hc == 4'h0 && !err && !f23) |=> (tx.valid && tx.data == `MBRW_FC_WR_MULTI))
    else $error("write-multiple answer does not start with its code");
  chk_fc16_five_bytes: assert property (@(posedge sys_clk) disable iff (rst)
    (st == S_HDR && free && !err && !f23) |=> (tx.last == (hc == `MBRW_RSP16_LEN)))
    else $error("write-multiple answer is not five bytes");
  chk_one_read_each: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en |=> (!rd_en ##1 !rd_en))
    else $error("read strobe repeated without a sent word");
  chk_read_address: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(rd_en) |-> (rd_addr == a_rd + 16'(k) && k < q_rd[6:0]))
    else $error("read address outside the requested block");
  // the last word's strobe lands one cycle after the frame ends, never later
  chk_write_before_read: assert property (@(posedge sys_clk) disable iff (rst)
    (st != S_RX && $past(st) != S_RX) |-> !wr.en)
    else $error("register write after the request ended");
  chk_tcp_only_rw: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en |-> (tcp_q && f23 && !err))
    else $error("read-write serviced outside TCP");
  chk_byte_count: assert property (@(posedge sys_clk) disable iff (rst)
    wr.en |-> (h[hl[3:0] - 4'h1] == {q_wr[6:0], 1'b0}))
    else $error("write done with a bad byte count");
  chk_write_range: assert property (@(posedge sys_clk) disable iff (rst)
    wr.en |-> (q_wr != 16'h0000 && q_wr <= (f23 ? `MBRW_Q23_WR_MAX : `MBRW_Q16_MAX)))
    else $error("write done with quantity out of range");
  chk_exception_form: assert property (@(posedge sys_clk) disable iff (rst)
    (st == S_HDR && free && err && hc == 4'h1) |=> (tx.data == exc && tx.last && $past(st) == S_HDR))
    else $error("exception answer malformed");
endmodule : mbrw_handler
`default_nettype wire

// [shared/mbrw_params.svh]
// constants for the multi-register write / read-write command handler
// assumes a framer that strips transport header and checksum before it
//
// How it works
// - function 16 answer echoes code, address, quantity
// - same function 16 answer for either transport
// - function 23 does one read, one write
// - write at write address, read at read
// - all writes finish before any read
// - function 23 only accepted over TCP
// - byte count equals twice register quantity
// - error answer: code with top bit, reason
`ifndef MBRW_PARAMS_SVH
`define MBRW_PARAMS_SVH
`define MBRW_FC_WR_MULTI   8'h10
`define MBRW_FC_RW_MULTI   8'h17
`define MBRW_EXC_FLAG      8'h80
`define MBRW_EXC_NONE      8'h00
`define MBRW_EXC_ILL_FUNC  8'h01
`define MBRW_EXC_ILL_VALUE 8'h03
`define MBRW_Q16_MAX       16'h007b
`define MBRW_Q23_RD_MAX    16'h007d
`define MBRW_Q23_WR_MAX    16'h0079
`define MBRW_HDR16_LEN     9'h006
`define MBRW_HDR23_LEN     9'h00a
`define MBRW_HDR_SLOTS     10
`define MBRW_RSP16_LEN     4'h5
`define MBRW_RSP_SHORT     4'h2
`endif

// [shared/mbrw_pkg.sv]
// types shared by the command handler and its neighbours
// assumes nothing beyond the params header
package mbrw_pkg;
  // byte from the framer, one protocol data unit per first..last
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } mbrw_rx_t;
  // answer byte towards the framer
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } mbrw_tx_t;
  // register store write strobe
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [15:0] data;
  } mbrw_wr_t;
  typedef enum logic [2:0] {S_RX, S_HDR, S_RDREQ, S_RDCAP, S_DHI, S_DLO, S_END} mbrw_state_t;
endpackage : mbrw_pkg
